// [rtl/pvcs_regs_top.sv]
`timescale 1ns/1ns
`include "pvcs_regs.svh"

module pvcs_regs_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // phy core status
  input  wire logic [4:0]          strap_addr,
  input  wire pvcs_pkg::pvcs_an_e  an_state,
  input  wire logic                pol_reversed,
  input  wire pvcs_pkg::pvcs_mode_s line_mode,
  // phy core controls
  output logic      [4:0]          station_addr,
  output logic                     link_pulse_tx,
  output logic                     force_good_link,
  output logic                     heartbeat_on,
  output logic                     squelch_low,
  output logic                     jabber_on,
  output logic      [8:0]          pd_gate,
  // interrupt
  output logic                     irq
);

  // register state; the status samples double as edge detectors
  // for the interrupt events
  logic [4:0]               addr_ff;
  logic                     strap_done_ff;
  pvcs_pkg::pvcs_cfg_s      cfg_ff;
  logic [`PVCS_PD_HI:0]     pdt_ff;
  logic                     pdsel_ff;
  logic [2:0]               istat_ff;
  logic [2:0]               imask_ff;
  logic [31:0]              rdata_ff;
  logic                     pol_ff;
  pvcs_pkg::pvcs_an_e       an_ff;

  // next values
  logic [4:0]               nxt_addr;
  pvcs_pkg::pvcs_cfg_s      nxt_cfg;
  logic [`PVCS_PD_HI:0]     nxt_pdt;
  logic                     nxt_pdsel;
  logic [2:0]               nxt_istat;
  logic [2:0]               nxt_imask;

  // register map by word index; the byte address is four times it
  //   specified status: station address rw, monitor code ro
  //   config/status: four 10BASE-T enables rw, polarity flag ro
  //   power-down test: nine gate bits rw, upper bits read zero
  //   manual select: one rw bit that arms the gate bits
  //   interrupt status: sticky events, cleared by reading them
  //   interrupt mask: same layout as the status word
  //   any other index: error response, reads as zero

  // bus decode; only the word index matters, byte lanes are ignored
  // setup and access are split so reads capture early, writes land late
  wire [5:0]  idx      = paddr[7:2];
  wire        setup    = psel & ~penable;
  wire        access   = psel & penable;
  wire        wr       = access & pwrite;
  wire        rd_setup = setup & ~pwrite;
  wire        hit_spec = (idx == `PVCS_IDX_SPEC_STAT);
  wire        hit_cfg  = (idx == `PVCS_IDX_CFG);
  wire        hit_pdt  = (idx == `PVCS_IDX_PDT);
  wire        hit_sel  = (idx == `PVCS_IDX_PDSEL);
  wire        hit_ist  = (idx == `PVCS_IDX_ISTAT);
  wire        hit_imk  = (idx == `PVCS_IDX_IMASK);
  wire        hit_any  = hit_spec | hit_cfg | hit_pdt |
                         hit_sel | hit_ist | hit_imk;

  // zero wait states: every access phase completes at once; every
  // readable field is a flop, so the read word settles in setup and
  // no stretch of the access phase is ever needed
  assign pready  = 1'b1;

  // an unmapped index answers with an error and reads as zero
  assign pslverr = access & ~hit_any;
  assign prdata  = rdata_ff;

  // read words; unlisted bits stay zero
  // a field that is not stored is a constant zero in its word
  wire [31:0] rd_spec;
  wire [31:0] rd_cfg;
  wire [31:0] rd_pdt;
  wire [31:0] rd_sel;
  wire [31:0] rd_ist;
  wire [31:0] rd_imk;
  wire [31:0] rd_mux;

  // specified status word: station address above the monitor code
  assign rd_spec = {23'h000000, addr_ff, an_ff};
  // reserved 15 and 10..1 are never driven, so they read zero
  assign rd_cfg  = {16'h0000, 1'b0, cfg_ff,
                    10'h000, pol_ff};
  assign rd_pdt  = {23'h000000, pdt_ff};
  assign rd_sel  = {31'h00000000, pdsel_ff};
  assign rd_ist  = {29'h00000000, istat_ff};
  assign rd_imk  = {29'h00000000, imask_ff};

  // a priority chain is harmless here: the hit lines are exclusive
  assign rd_mux = hit_spec ? rd_spec :
                  hit_cfg  ? rd_cfg  :
                  hit_pdt  ? rd_pdt  :
                  hit_sel  ? rd_sel  :
                  hit_ist  ? rd_ist  :
                  hit_imk  ? rd_imk  : 32'h00000000;

  // events from the phy core, each found by comparing the live input
  // with last cycle's sample, so a code held for long counts once
  // completion: the monitor code has just become the done code
  wire an_ok_ev   = (an_state == pvcs_pkg::AN_DONE) &
                    (an_ff != pvcs_pkg::AN_DONE);

  // failure: any of the three fail codes, on the cycle it appears
  wire an_fail_st = (an_state == pvcs_pkg::AN_ACK_FAIL) |
                    (an_state == pvcs_pkg::AN_CONS_FAIL) |
                    (an_state == pvcs_pkg::AN_PD_FAIL);
  wire an_fail_ev = an_fail_st & (an_state != an_ff);

  // polarity: a change in either direction is reported
  wire pol_ev     = pol_reversed ^ pol_ff;
  // event vector in status-bit order
  wire [2:0] ev_set;
  assign ev_set[`PVCS_EV_POL]    = pol_ev;
  assign ev_set[`PVCS_EV_ANOK]   = an_ok_ev;
  assign ev_set[`PVCS_EV_ANFAIL] = an_fail_ev;

  // read-clear removes only the bits that were returned, so an event
  // landing between setup and access survives; set wins over clear
  // the status word has no write path: only events and reads move it
  wire       ist_rd  = access & ~pwrite & hit_ist;
  wire [2:0] ist_clr = ist_rd ? rdata_ff[2:0] : 3'h0;
  assign nxt_istat = (istat_ff & ~ist_clr) | ev_set;

  // one write strobe per writable register, all taken at the access edge;
  // an unmapped index matches none, so a stray write changes nothing
  wire        wr_spec  = wr & hit_spec;
  wire        wr_cfg   = wr & hit_cfg;
  wire        wr_pdt   = wr & hit_pdt;
  wire        wr_sel   = wr & hit_sel;
  wire        wr_imk   = wr & hit_imk;

  // software writes; reserved bits are simply not stored
  assign nxt_addr  = wr_spec ?
                     pwdata[`PVCS_ADDR_HI:`PVCS_ADDR_LO] : addr_ff;
  assign nxt_cfg   = wr_cfg ?
                     pwdata[`PVCS_LP_BIT:`PVCS_JAB_BIT] : cfg_ff;
  assign nxt_pdt   = wr_pdt ?
                     pwdata[`PVCS_PD_HI:0] : pdt_ff;
  assign nxt_pdsel = wr_sel ?
                     pwdata[`PVCS_SEL_BIT] : pdsel_ff;
  assign nxt_imask = wr_imk ? pwdata[2:0] : imask_ff;

  // station address: strap caught at the first edge after release,
  // since an async reset may only load a constant; software leaves
  // that first edge free, as a write there is overwritten by the strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff       <= 5'h00;
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
      addr_ff       <= strap_done_ff ? nxt_addr : strap_addr;
    end
  end

  // 10BASE-T controls; all four come out of reset enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= `PVCS_CFG_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // power-down test bits; kept while manual control is off, so
  // software can stage a pattern before it selects manual mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdt_ff <= `PVCS_PD_RST;
    end else begin
      pdt_ff <= nxt_pdt;
    end
  end

  // manual power-down select, off after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdsel_ff <= `PVCS_SEL_RST;
    end else begin
      pdsel_ff <= nxt_pdsel;
    end
  end

  // polarity sample, used for both readback and the change event;
  // it follows the line in both directions with no software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_ff <= 1'b0;
    end else begin
      pol_ff <= pol_reversed;
    end
  end

  // monitor code sample, for readback and the event compare; one cycle of lag is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_ff <= pvcs_pkg::AN_IDLE;
    end else begin
      an_ff <= an_state;
    end
  end

  // sticky interrupt status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= `PVCS_EV_RST;
    end else begin
      istat_ff <= nxt_istat;
    end
  end

  // interrupt mask, every event masked after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_ff <= `PVCS_EV_RST;
    end else begin
      imask_ff <= nxt_imask;
    end
  end

  // read data held from setup through the access phase;
  // capturing at setup fixes which status bits a read may clear,
  // so an event in the access cycle is kept for the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_setup) begin
      rdata_ff <= rd_mux;
    end
  end

  // the serial management engine shifts bit 4 out first
  // and matches incoming frames against this address
  assign station_addr = addr_ff;

  // link pulses only matter at 10 Mbps
  // at 100 Mbps both outputs rest low, so the core sees neither
  assign link_pulse_tx   = line_mode.ten_mbps & cfg_ff.lp;
  assign force_good_link = line_mode.ten_mbps & ~cfg_ff.lp;

  // collision test is meaningless in full duplex
  // the enable is kept, so it returns when half duplex does
  assign heartbeat_on = cfg_ff.hb & ~line_mode.full_dup;

  // select 1 keeps the normal level, so the low output is its inverse
  assign squelch_low = ~cfg_ff.sq;

  // outside the two named modes jabber protection stays on
  // (the safe side: there the bit has no meaning and is ignored)
  wire jab_mode = line_mode.ten_mbps &
                  (line_mode.full_dup | line_mode.loopback);
  assign jabber_on = jab_mode ? cfg_ff.jab : 1'b1;

  // test gates are inert until manual control is selected; clearing
  // the select drops every gate at once, whatever the test bits hold
  genvar g;
  for (g = 0; g <= `PVCS_PD_HI; g++) begin : g_pd_gate
    assign pd_gate[g] = pdsel_ff & pdt_ff[g];
  end

  // level interrupt, high while any unmasked status bit is set;
  // it drops in the cycle after the read that clears the last bit
  assign irq = |(istat_ff & imask_ff);

endmodule // pvcs_regs_top

// [inc/pvcs_regs.svh]
`ifndef PVCS_REGS_SVH
`define PVCS_REGS_SVH

// word indices; byte address is four times the index
`define PVCS_IDX_SPEC_STAT 6'h10
`define PVCS_IDX_CFG       6'h11
`define PVCS_IDX_PDT       6'h13
`define PVCS_IDX_PDSEL     6'h14
`define PVCS_IDX_ISTAT     6'h18
`define PVCS_IDX_IMASK     6'h19

// specified status word fields
`define PVCS_ADDR_HI 8
`define PVCS_ADDR_LO 4
`define PVCS_AN_HI   3
`define PVCS_AN_LO   0

// config/status word fields
`define PVCS_LP_BIT  14
`define PVCS_HB_BIT  13
`define PVCS_SQ_BIT  12
`define PVCS_JAB_BIT 11
`define PVCS_POL_BIT 0
`define PVCS_CFG_RST 4'hF

// power-down test and manual select word fields
`define PVCS_PD_HI   8
`define PVCS_PD_RST  9'h000
`define PVCS_SEL_BIT 0
`define PVCS_SEL_RST 1'b0

// interrupt status / mask fields
`define PVCS_EV_POL    0
`define PVCS_EV_ANOK   1
`define PVCS_EV_ANFAIL 2
`define PVCS_EV_RST    3'h0

`endif

// [inc/pvcs_pkg.sv]
package pvcs_pkg;

  // auto-negotiation monitor codes
  typedef enum logic [3:0] {
    AN_IDLE      = 4'h0,
    AN_ABIL      = 4'h1,
    AN_ACK       = 4'h2,
    AN_ACK_FAIL  = 4'h3,
    AN_CONS      = 4'h4,
    AN_CONS_FAIL = 4'h5,
    AN_PD_RDY    = 4'h6,
    AN_PD_FAIL   = 4'h7,
    AN_DONE      = 4'h8
  } pvcs_an_e;

  // software-set 10BASE-T controls
  typedef struct packed {
    logic lp;
    logic hb;
    logic sq;
    logic jab;
  } pvcs_cfg_s;

  // line operating mode from the PHY core
  typedef struct packed {
    logic ten_mbps;
    logic full_dup;
    logic loopback;
  } pvcs_mode_s;

endpackage

// [testbench/pvcs_regs_chk.sv]
`timescale 1ns/1ns
module pvcs_regs_chk #(parameter int ADDR_W = 8) (
  // clock, reset and apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  // phy core side
  input wire logic [4:0]        strap_addr,
  input wire pvcs_pkg::pvcs_mode_s line_mode,
  input wire logic [4:0]        station_addr,
  input wire logic              link_pulse_tx,
  input wire logic              force_good_link,
  input wire logic              heartbeat_on,
  input wire logic              jabber_on,
  input wire logic [8:0]        pd_gate
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read access phases of the two checked words
  wire logic rd_acc = psel & penable & ~pwrite;
  wire logic rd_cfg = rd_acc & (paddr[7:2] == 6'h11);
  wire logic rd_pdt = rd_acc & (paddr[7:2] == 6'h13);
  property p_strap; $rose(presetn) |=> station_addr == $past(strap_addr);
  endproperty
  a_strap: assert property (p_strap) else $error("strap lost");
  property p_cfg_rsv; rd_cfg |-> !prdata[15] && prdata[10:1] == 10'h000;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("cfg rsv");
  property p_pdt_rsv; rd_pdt |-> prdata[31:9] == 23'h000000; endproperty
  a_pdt_rsv: assert property (p_pdt_rsv) else $error("pdt rsv");
  property p_lp_off; !line_mode.ten_mbps |-> !(link_pulse_tx|force_good_link);
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("lp not 10M");
  property p_lp_xor; line_mode.ten_mbps |-> link_pulse_tx ^ force_good_link;
  endproperty
  a_lp_xor: assert property (p_lp_xor) else $error("lp vs link");
  property p_hb; line_mode.full_dup |-> !heartbeat_on; endproperty
  a_hb: assert property (p_hb) else $error("heartbeat in fdx");
  property p_jab;
    !(line_mode.ten_mbps & (line_mode.full_dup | line_mode.loopback))
      |-> jabber_on;
  endproperty
  a_jab: assert property (p_jab) else $error("jabber off");
  // gating moves only as the result of a register write
  property p_gate;
    pd_gate != $past(pd_gate) |-> $past(psel & penable & pwrite);
  endproperty
  a_gate: assert property (p_gate) else $error("gate moved");
endmodule // pvcs_regs_chk
bind pvcs_regs_top pvcs_regs_chk #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .strap_addr(strap_addr),
  .line_mode(line_mode), .station_addr(station_addr),
  .link_pulse_tx(link_pulse_tx), .force_good_link(force_good_link),
  .heartbeat_on(heartbeat_on), .jabber_on(jabber_on), .pd_gate(pd_gate));

// [testbench/pvcs_sme_mdl.sv]
`timescale 1ns/1ns
module pvcs_sme_mdl (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial psel = 1'b0;
  initial penable = 1'b0;
  // one transfer; entered just after an edge, leaves one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e,
    output logic to);
    int n;
    psel <= 1'b1; // address used exactly as given
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= (a[7:2] == 6'h11) ? (d & 32'h00007800) : d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // pvcs_sme_mdl

// [testbench/test_pvcs_regs_top.sv]
`timescale 1ns/1ns
module test_pvcs_regs_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, to;
  logic pol_reversed, link_pulse_tx, force_good_link, heartbeat_on;
  logic squelch_low, jabber_on, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] strap_addr, station_addr;
  logic [8:0] pd_gate;
  pvcs_pkg::pvcs_an_e an_state;
  pvcs_pkg::pvcs_mode_s line_mode;
  int mismatches, checks_done, c;
  int mdl[int]; // register model by word index
  pvcs_sme_mdl i_sme (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  pvcs_regs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_addr(strap_addr), .an_state(an_state),
    .pol_reversed(pol_reversed), .line_mode(line_mode),
    .station_addr(station_addr), .link_pulse_tx(link_pulse_tx),
    .force_good_link(force_good_link), .heartbeat_on(heartbeat_on),
    .squelch_low(squelch_low), .jabber_on(jabber_on), .pd_gate(pd_gate),
    .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    checks_done++;
    if (sn !== ex) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, ex, sn);
    end
  endtask
  task end_of_test;
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // a hung handshake ends the run at once
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_sme.xfer(w, a, d, q, e, to);
    if (to) begin
      mismatches++;
      end_of_test;
    end
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    acc(1'b0, a, 32'h00000000);
    chk(nm, ex, q);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    mdl[a[7:2]] = d & ((a == 8'h44) ? 32'h7800 : 32'h1FF);
  endtask
  // control outputs against the model and the line mode
  task outs;
    c = mdl[17];
    chk("lp", c[14] & line_mode.ten_mbps, link_pulse_tx);
    chk("fgl", !c[14] & line_mode.ten_mbps, force_good_link);
    chk("hb", c[13] & !line_mode.full_dup, heartbeat_on);
    chk("sq", !c[12], squelch_low);
    chk("jab", (line_mode.ten_mbps & (line_mode.full_dup |
      line_mode.loopback)) ? c[11] : 1'b1, jabber_on);
  endtask
  initial begin
    presetn = 1'b0;
    an_state = pvcs_pkg::AN_IDLE;
    pol_reversed = 1'b0;
    line_mode = 3'h0;
    c = $urandom(32'hF6D1A009);
    strap_addr = 5'($urandom);
    mdl[17] = 32'h7800;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd("cfg", 8'h44, 32'h00007800);
    rd("pdt", 8'h4C, 32'h00000000);
    chk("sa", strap_addr, station_addr);
    // every monitor code; fail and done codes also set status bits
    for (int i = 0; i < 9; i++) begin
      an_state <= pvcs_pkg::pvcs_an_e'(i);
      repeat (3) @(posedge pclk);
      rd("an", 8'h40, {strap_addr, 4'(i)});
    end
    repeat (6) begin
      line_mode <= 3'($urandom);
      wr(8'h44, $urandom);
      rd("cfg", 8'h44, mdl[17]);
      outs;
    end
    wr(8'h4C, 32'hFFFFFFFF);
    rd("pdt", 8'h4C, 32'h000001FF);
    chk("gate", 32'h0, pd_gate);
    acc(1'b1, 8'h50, 32'h00000001);
    chk("gate", 32'h1FF, pd_gate);
    // masked events stay quiet, then one is unmasked and read away
    chk("irq", 32'h0, irq);
    rd("ist", 8'h60, 32'h00000006);
    acc(1'b1, 8'h64, 32'h00000001);
    pol_reversed <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("irq", 32'h1, irq);
    rd("pol", 8'h44, mdl[17] | 1);
    rd("ist", 8'h60, 32'h00000001);
    chk("irq", 32'h0, irq);
    rd("bad", 8'h7C, 32'h00000000);
    chk("err", 32'h1, e);
    // polarity back to normal clears the flag and reports a change
    pol_reversed <= 1'b0;
    repeat (4) @(posedge pclk);
    rd("pol", 8'h44, mdl[17]);
    rd("ist", 8'h60, 32'h00000001);
    // station address is writable once the strap is loaded
    c = $urandom;
    acc(1'b1, 8'h40, c);
    rd("sa", 8'h40, (c & 32'h1F0) | 32'h8);
    chk("err", 32'h0, e);
    chk("sa", c[8:4], station_addr);
    end_of_test;
  end
endmodule // test_pvcs_regs_top
